// ===== rtl/ctp_term_cfg.sv
`timescale 1ns/1ns
module ctp_term_cfg
   import ctp_pkg::*;
#(
   parameter int SEC_CYCLES = CLK_HZ
)
(
   // Clock and reset
   input  wire logic          clock,
   input  wire logic          rst_n,
   // AHB-Lite slave
   input  wire logic          hsel,
   input  wire logic [31:0]   haddr,
   input  wire logic [1:0]    htrans,
   input  wire logic          hwrite,
   input  wire logic [2:0]    hsize,
   input  wire logic [31:0]   hwdata,
   input  wire logic          hready,
   output logic [31:0]        hrdata,
   output logic               hreadyout,
   output logic               hresp,
   // Gauge measurements and events
   input  wire ctp_meas_t     meas,
   input  wire logic          temp_rise_seen,
   input  wire logic [15:0]   cell_volt [4],
   // Results
   output logic               full_charged,
   output logic               charge_term,
   output logic [7:0]         led_soc,
   output ctp_pack_opt_t      pack_opt,
   output logic [15:0]        pack_voltage_out,
   output logic [3:0]         cell_input_active,
   output logic [5:0]         rise_tenths_c,
   output logic               cfg_loaded
);

   ////////////////////////////////////////////////////////////////////////
   // Register storage
   logic [15:0] run_alarm_ff, cap_alarm_ff, cyc_thr_ff;
   logic [7:0]  pack_opt_ff, temp_rise_ff, resync_pct_ff, full_clr_ff;
   logic [7:0]  window_ff, holdoff_ff, cmd_probe_ff;
   logic [15:0] remaining_ff, full_cap_ff, disch_acc_ff, cycle_ff;
   logic        cfg_loaded_ff, full_ff, term_ff;
   logic        dphase_ff, dwrite_ff;
   logic [9:0]  daddr_ff;
   logic [31:0] rdata_ff;

   assign pack_opt   = ctp_pack_opt_t'(pack_opt_ff);
   assign hreadyout  = 1'b1;
   assign hresp      = 1'b0;
   assign hrdata     = rdata_ff;
   assign cfg_loaded = cfg_loaded_ff;

   ////////////////////////////////////////////////////////////////////////
   // Bus address phase capture
   wire addr_ok = hsel & hready & htrans[1];
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         dphase_ff <= 1'b0;
         dwrite_ff <= 1'b0;
         daddr_ff  <= 10'h000;
      end
      else
      begin
         dphase_ff <= addr_ok;
         dwrite_ff <= addr_ok & hwrite;
         if (addr_ok)
            daddr_ff <= haddr[9:0];
      end

   wire wr = dphase_ff & dwrite_ff;

   ////////////////////////////////////////////////////////////////////////
   // Configuration writes; config counts as loaded once the pack byte lands
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         run_alarm_ff  <= WORD_RST;
         cap_alarm_ff  <= WORD_RST;
         cyc_thr_ff    <= WORD_RST;
         pack_opt_ff   <= PACK_OPT_RST;
         temp_rise_ff  <= 8'h00;
         resync_pct_ff <= 8'h00;
         full_clr_ff   <= 8'h00;
         window_ff     <= 8'h00;
         holdoff_ff    <= 8'h00;
         cmd_probe_ff  <= 8'h00;
         full_cap_ff   <= WORD_RST;
         cfg_loaded_ff <= 1'b0;
      end
      else if (wr)
         case (daddr_ff)
            REG_RUN_ALARM_OFS:  run_alarm_ff  <= hwdata[15:0];
            REG_CAP_ALARM_OFS:  cap_alarm_ff  <= hwdata[15:0];
            REG_CYC_THR_OFS:    cyc_thr_ff    <= hwdata[15:0];
            REG_PACK_OPT_OFS:
            begin
               pack_opt_ff   <= hwdata[7:0];
               cfg_loaded_ff <= 1'b1;
            end
            REG_TEMP_RISE_OFS:  temp_rise_ff  <= hwdata[7:0];
            REG_RESYNC_PCT_OFS: resync_pct_ff <= hwdata[7:0];
            REG_FULL_CLR_OFS:   full_clr_ff   <= hwdata[7:0];
            REG_WINDOW_OFS:     window_ff     <= hwdata[7:0];
            REG_HOLDOFF_OFS:    holdoff_ff    <= hwdata[7:0];
            REG_CMD_CHK_OFS:    cmd_probe_ff  <= hwdata[7:0];
            REG_GAUGE_OFS:      full_cap_ff   <= hwdata[31:16];
            default:            cmd_probe_ff  <= cmd_probe_ff;
         endcase

   ////////////////////////////////////////////////////////////////////////
   // Two's complement stored values decoded to plain magnitudes
   wire [7:0]  full_clr_pct = 8'(-full_clr_ff);
   wire [7:0]  resync_pct   = 8'(-resync_pct_ff);
   wire [15:0] cyc_thr      = 16'(-cyc_thr_ff);

   ////////////////////////////////////////////////////////////////////////
   // Seconds tick
   logic [27:0] sec_cnt_ff;
   wire         sec_tick = (sec_cnt_ff == 28'(SEC_CYCLES - 1));
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         sec_cnt_ff <= 28'h0000000;
      else
         sec_cnt_ff <= sec_tick ? 28'h0000000 : sec_cnt_ff + 28'h0000001;

   ////////////////////////////////////////////////////////////////////////
   // Rise, window and hold-off decode
   assign rise_tenths_c = 6'(({2'b00, temp_rise_ff[3:0]} << 1) + 6'd16);
   wire [8:0] window_s  = 9'(SEC_BASE_S - SEC_STEP_S * window_ff[3:0]);
   wire [8:0] holdoff_s = 9'(SEC_BASE_S - SEC_STEP_S * holdoff_ff[3:0]);

   // Hold-off runs from charge start, then rise checked per window
   logic [8:0] hold_cnt_ff, win_cnt_ff;
   logic       rate_term_ff;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         hold_cnt_ff  <= 9'h000;
         win_cnt_ff   <= 9'h000;
         rate_term_ff <= 1'b0;
      end
      else if (!meas.charging || !cfg_loaded_ff)
      begin
         hold_cnt_ff  <= 9'h000;
         win_cnt_ff   <= 9'h000;
         rate_term_ff <= 1'b0;
      end
      else if (sec_tick)
      begin
         if (hold_cnt_ff < holdoff_s)
            hold_cnt_ff <= hold_cnt_ff + 9'h001;
         else if (win_cnt_ff < window_s)
         begin
            win_cnt_ff <= win_cnt_ff + 9'h001;
            if (temp_rise_seen)
               rate_term_ff <= 1'b1;
         end
         else
            win_cnt_ff <= 9'h000;
      end

   ////////////////////////////////////////////////////////////////////////
   // Lithium current taper; margin code is mV/2, threshold code raw
   wire [15:0] taper_margin = {7'h00, holdoff_ff, 1'b0};
   wire [15:0] taper_i      = {8'h00, window_ff};
   wire taper_qual = pack_opt_ff[PO_CHEMISTRY_SELECT] && meas.charging &&
                     (meas.pack_voltage > meas.charging_voltage - taper_margin) &&
                     (meas.charge_current < taper_i);
   logic [6:0] taper_cnt_ff;
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         taper_cnt_ff <= 7'h00;
      else if (!taper_qual || !cfg_loaded_ff)
         taper_cnt_ff <= 7'h00;
      else if (sec_tick && taper_cnt_ff < 7'(TAPER_S))
         taper_cnt_ff <= taper_cnt_ff + 7'h01;

   wire term_now = rate_term_ff | (taper_cnt_ff == 7'(TAPER_S));
   wire term_rise = term_now & ~term_ff;

   ////////////////////////////////////////////////////////////////////////
   // Termination, remaining capacity resync and full flag
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         term_ff      <= 1'b0;
         remaining_ff <= WORD_RST;
         full_ff      <= 1'b0;
      end
      else
      begin
         term_ff <= term_now;
         if (wr && daddr_ff == REG_GAUGE_OFS)
            remaining_ff <= hwdata[15:0];
         if (term_rise && pack_opt_ff[PO_SYNC])
            remaining_ff <= 16'((32'(full_cap_ff) * resync_pct) / 100);
         if (term_rise)
            full_ff <= 1'b1;
         else if (meas.rel_soc <= full_clr_pct)
            full_ff <= 1'b0;
      end

   assign full_charged = full_ff;
   assign charge_term  = term_ff;

   ////////////////////////////////////////////////////////////////////////
   // Cycle counting on discharged charge
   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
      begin
         disch_acc_ff <= WORD_RST;
         cycle_ff     <= WORD_RST;
      end
      else if (wr && daddr_ff == REG_DISCH_OFS)
      begin
         if (17'(disch_acc_ff) + 17'(hwdata[15:0]) >= 17'(cyc_thr) && cyc_thr != 0)
         begin
            disch_acc_ff <= 16'(disch_acc_ff + hwdata[15:0] - cyc_thr);
            cycle_ff     <= cycle_ff + 16'h0001;
         end
         else
            disch_acc_ff <= disch_acc_ff + hwdata[15:0];
      end

   ////////////////////////////////////////////////////////////////////////
   // LED source, cell map and pack voltage
   assign led_soc = pack_opt_ff[PO_LED_SRC] ? meas.rel_soc : meas.abs_soc;
   wire [1:0] cc = {pack_opt_ff[PO_CC1], pack_opt_ff[PO_CC0]};
   always_comb
   begin
      case (cc)
         2'b00:   cell_input_active = 4'b1000;
         2'b01:   cell_input_active = 4'b0011;
         2'b10:   cell_input_active = 4'b0111;
         default: cell_input_active = 4'b1111;
      endcase
   end
   assign pack_voltage_out = (cc == 2'b00) ? cell_volt[3] : cell_volt[cc];

   ////////////////////////////////////////////////////////////////////////
   // Bus command access check against the lock bit
   wire lk = pack_opt_ff[PO_LOCK] & cfg_loaded_ff;
   wire c_rw = (cmd_probe_ff <= RW_HI0) || (cmd_probe_ff == RW_ONE) ||
               (cmd_probe_ff >= RW_LO1 && cmd_probe_ff <= RW_HI1);
   wire c_ro = (cmd_probe_ff >= RO_LO0 && cmd_probe_ff <= RO_HI0) ||
               (cmd_probe_ff >= RO_LO1 && cmd_probe_ff <= RO_HI1);
   wire cmd_rd_ok = !lk || c_rw || c_ro;
   wire cmd_wr_ok = !lk || c_rw;

   ////////////////////////////////////////////////////////////////////////
   // Read mux, one wait-free data phase
   logic [31:0] rd_mux;
   always_comb
   begin
      case (haddr[9:0])
         REG_RUN_ALARM_OFS:  rd_mux = {16'h0000, run_alarm_ff};
         REG_CAP_ALARM_OFS:  rd_mux = {16'h0000, cap_alarm_ff};
         REG_CYC_THR_OFS:    rd_mux = {16'h0000, cyc_thr_ff};
         REG_PACK_OPT_OFS:   rd_mux = {24'h000000, pack_opt_ff};
         REG_TEMP_RISE_OFS:  rd_mux = {24'h000000, temp_rise_ff};
         REG_RESYNC_PCT_OFS: rd_mux = {24'h000000, resync_pct_ff};
         REG_FULL_CLR_OFS:   rd_mux = {24'h000000, full_clr_ff};
         REG_WINDOW_OFS:     rd_mux = {24'h000000, window_ff};
         REG_HOLDOFF_OFS:    rd_mux = {24'h000000, holdoff_ff};
         REG_STATUS_OFS:     rd_mux = {24'h000000, pack_opt_ff[PO_EDV],
                                       pack_opt_ff[PO_MIDRANGE_CORRECTION_ENABLE],
                                       pack_opt_ff[PO_CHEMISTRY_SELECT],
                                       cmd_wr_ok, cmd_rd_ok, cfg_loaded_ff,
                                       term_ff, full_ff};
         REG_CMD_CHK_OFS:    rd_mux = {24'h000000, cmd_probe_ff};
         REG_GAUGE_OFS:      rd_mux = {full_cap_ff, remaining_ff};
         REG_DISCH_OFS:      rd_mux = {16'h0000, disch_acc_ff};
         REG_CYCLE_OFS:      rd_mux = {16'h0000, cycle_ff};
         default:            rd_mux = 32'h00000000;
      endcase
   end

   always_ff @(posedge clock or negedge rst_n)
      if (!rst_n)
         rdata_ff <= 32'h00000000;
      else if (addr_ok && !hwrite)
         rdata_ff <= rd_mux;

   // Unused bus sideband
   wire unused_ok = ^{hsize, haddr[31:10], htrans[0]};

endmodule : ctp_term_cfg

// ===== rtl/ctp_pkg.sv
package ctp_pkg;
   // Configuration indexes; each register is one word at four times its index
   localparam logic [7:0] CFG_IDX_RUN_ALARM = 8'h02;
   localparam logic [7:0] CFG_IDX_CAP_ALARM = 8'h04;
   localparam logic [7:0] CFG_IDX_CYC_THR   = 8'h3c;
   localparam logic [7:0] CFG_IDX_PACK_OPT  = 8'h3f;
   localparam logic [7:0] CFG_IDX_TEMP_RISE = 8'h45;
   localparam logic [7:0] CFG_IDX_RESYNC    = 8'h4b;
   localparam logic [7:0] CFG_IDX_FULL_CLR  = 8'h4c;
   localparam logic [7:0] CFG_IDX_WINDOW    = 8'h4e;
   localparam logic [7:0] CFG_IDX_HOLDOFF   = 8'h4f;
   // Register byte addresses
   localparam logic [9:0] REG_RUN_ALARM_OFS   = {CFG_IDX_RUN_ALARM, 2'b00};
   localparam logic [9:0] REG_CAP_ALARM_OFS   = {CFG_IDX_CAP_ALARM, 2'b00};
   localparam logic [9:0] REG_CYC_THR_OFS     = {CFG_IDX_CYC_THR, 2'b00};
   localparam logic [9:0] REG_PACK_OPT_OFS    = {CFG_IDX_PACK_OPT, 2'b00};
   localparam logic [9:0] REG_TEMP_RISE_OFS   = {CFG_IDX_TEMP_RISE, 2'b00};
   localparam logic [9:0] REG_RESYNC_PCT_OFS  = {CFG_IDX_RESYNC, 2'b00};
   localparam logic [9:0] REG_FULL_CLR_OFS    = {CFG_IDX_FULL_CLR, 2'b00};
   localparam logic [9:0] REG_WINDOW_OFS      = {CFG_IDX_WINDOW, 2'b00};
   localparam logic [9:0] REG_HOLDOFF_OFS     = {CFG_IDX_HOLDOFF, 2'b00};
   localparam logic [9:0] REG_STATUS_OFS      = 10'h140; // block state, read only
   localparam logic [9:0] REG_CMD_CHK_OFS     = 10'h144; // bus command access probe
   localparam logic [9:0] REG_GAUGE_OFS       = 10'h148; // remaining / full capacity inputs
   localparam logic [9:0] REG_DISCH_OFS       = 10'h14c; // discharged mAh increment
   localparam logic [9:0] REG_CYCLE_OFS       = 10'h150; // cycle count, read only
   // Pack option bit positions
   localparam int PO_LED_SRC = 7;
   localparam int PO_LOCK    = 6;
   localparam int PO_SYNC    = 5;
   localparam int PO_EDV     = 4;
   localparam int PO_MIDRANGE_CORRECTION_ENABLE    = 3;
   localparam int PO_CHEMISTRY_SELECT    = 2;
   localparam int PO_CC1     = 1;
   localparam int PO_CC0     = 0;
   // Reset values
   localparam logic [7:0]  PACK_OPT_RST = 8'h00;
   localparam logic [15:0] WORD_RST     = 16'h0000;
   // Timing
   localparam int CLK_HZ         = 250_000_000;
   localparam int SEC_BASE_S     = 320;
   localparam int SEC_STEP_S     = 20;
   localparam int TAPER_S        = 80;
   // Sealed access windows
   localparam logic [7:0] RO_LO0 = 8'h05;
   localparam logic [7:0] RO_HI0 = 8'h1c;
   localparam logic [7:0] RO_LO1 = 8'h20;
   localparam logic [7:0] RO_HI1 = 8'h23;
   localparam logic [7:0] RW_HI0 = 8'h04;
   localparam logic [7:0] RW_ONE = 8'h2f;
   localparam logic [7:0] RW_LO1 = 8'h3c;
   localparam logic [7:0] RW_HI1 = 8'h3f;

   // Decoded pack options
   typedef struct packed {
      logic       led_source_select;
      logic       bus_access_lock;
      logic       capacity_sync_enable;
      logic       edv_compensation_enable;
      logic       midrange_correction_enable;
      logic       chemistry_select;
      logic       cell_count_bit1;
      logic       cell_count_bit0;
   } ctp_pack_opt_t;

   // Measurement inputs from the gauge core
   typedef struct packed {
      logic [15:0] pack_voltage;
      logic [15:0] charging_voltage;
      logic [15:0] charge_current;
      logic [7:0]  rel_soc;
      logic [7:0]  abs_soc;
      logic        charging;
   } ctp_meas_t;
endpackage : ctp_pkg

// ===== tb/ctp_term_cfg_assertions.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Checker on the block's ports
module ctp_term_cfg_assertions
   import ctp_pkg::*;
(
   // Clock, reset and bus
   input wire logic           clock,
   input wire logic           rst_n,
   input wire logic           hsel,
   input wire logic [31:0]    haddr,
   input wire logic [1:0]     htrans,
   input wire logic           hwrite,
   input wire logic [31:0]    hwdata,
   input wire logic           hready,
   // Gauge side and results
   input wire ctp_meas_t      meas,
   input wire logic [15:0]    cell_volt [4],
   input wire logic           full_charged,
   input wire logic           charge_term,
   input wire logic [7:0]     led_soc,
   input wire ctp_pack_opt_t  pack_opt,
   input wire logic [15:0]    pack_voltage_out,
   input wire logic [3:0]     cell_input_active,
   input wire logic           cfg_loaded
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // Cell count code
   wire logic [1:0] cc = {pack_opt.cell_count_bit1, pack_opt.cell_count_bit0};
   // Option write: address phase then its data phase
   sequence opt_wr_s;
      hsel && hready && htrans[1] && hwrite && haddr == {22'h0, REG_PACK_OPT_OFS} ##1 1'b1;
   endsequence
   led_source_a: assert property (
      led_soc == (pack_opt.led_source_select ? meas.rel_soc : meas.abs_soc))
      else $error("LED level from wrong source");
   cell_map_a: assert property (
      cell_input_active == (cc == 2'h0 ? 4'h8 : cc == 2'h1 ? 4'h3 : cc == 2'h2 ? 4'h7 : 4'hf))
      else $error("Cell input map wrong");
   pack_volt_a: assert property (cc != 2'h0 |-> pack_voltage_out == cell_volt[cc])
      else $error("Pack voltage not from top cell");
   stack_volt_a: assert property (cc == 2'h0 |-> pack_voltage_out == cell_volt[3])
      else $error("Stack voltage not from input four");
   opt_write_a: assert property (opt_wr_s |=> pack_opt == $past(hwdata[7:0]))
      else $error("Option byte not taken");
   cfg_load_a: assert property (opt_wr_s |=> cfg_loaded)
      else $error("Config not marked loaded");
   term_full_a: assert property ($rose(charge_term) |-> ##[0:1] full_charged)
      else $error("Full flag not set at termination");
   term_charge_a: assert property ($rose(charge_term) |-> $past(meas.charging))
      else $error("Termination outside charging");
endmodule : ctp_term_cfg_assertions
bind ctp_term_cfg ctp_term_cfg_assertions u_chk (.clock, .rst_n, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .meas, .cell_volt, .full_charged, .charge_term, .led_soc,
   .pack_opt, .pack_voltage_out, .cell_input_active, .cfg_loaded);

// ===== tb/ctp_gauge_model.sv
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Gauge core and cell divider model
module ctp_gauge_model
   import ctp_pkg::*;
(
   // Clock and controls
   input  wire logic        clock,
   input  wire logic        chg,
   input  wire logic        heat,
   input  wire logic [7:0]  rel,
   // Measurements
   output ctp_meas_t        meas = '0,
   output logic             temp_rise_seen = 1'b0,
   output logic [15:0]      cell_volt [4]
);
   // One distinct level per cell input
   assign cell_volt = '{16'h0e01, 16'h1c02, 16'h2a03, 16'h3804};
   // Current stays above taper limit; levels move just after the edge
   always @(posedge clock)
   begin
      meas <= '{16'h3804, 16'h3a98, 16'h0fa0, rel, 8'h30, chg};
      temp_rise_seen <= heat & chg;
   end
endmodule : ctp_gauge_model

// ===== tb/test_ctp_term_cfg.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("MISMATCH %0t got %h exp %h", $time, a, b); end end
module test_ctp_term_cfg
   import ctp_pkg::*;
;
   logic clock = 0, rst_n = 0, hsel = 0, hwrite = 0, chg = 0, heat = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [1:0] htrans = 0;
   logic [7:0] rel = 8'h5f, led_soc;
   logic hreadyout, hresp, full_charged, charge_term, cfg_loaded, temp_rise_seen;
   logic [15:0] cell_volt [4];
   logic [15:0] pack_voltage_out;
   logic [3:0] cell_input_active;
   logic [5:0] rise_tenths_c;
   ctp_meas_t meas;
   ctp_pack_opt_t pack_opt;
   int bad_count = 0, n_tests = 0, i;
   logic [7:0] cmd [8] = '{8'h04, 8'h05, 8'h1c, 8'h1d, 8'h23, 8'h24, 8'h2f, 8'h3f};
   logic [1:0] acc [8] = '{2'h3, 2'h1, 2'h1, 2'h0, 2'h1, 2'h0, 2'h3, 2'h3};
   // Clock
   always #2 clock = ~clock;
   ctp_term_cfg #(.SEC_CYCLES(10)) u_dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .meas,
      .temp_rise_seen, .cell_volt, .full_charged, .charge_term, .led_soc, .pack_opt,
      .pack_voltage_out, .cell_input_active, .rise_tenths_c, .cfg_loaded);
   ctp_gauge_model u_gauge (.clock, .chg, .heat, .rel, .meas, .temp_rise_seen, .cell_volt);
   ////////////////////////////////////////////////////////////////////////////
   // One single word transfer
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {22'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge clock); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
      rd = hrdata;
      #1;
   endtask : bus
   // Probe command access under the present lock state
   task automatic probe(input logic [7:0] c, input logic [1:0] e);
      bus(1'b1, REG_CMD_CHK_OFS, {24'h0, c});
      bus(1'b0, REG_STATUS_OFS, 32'h0);
      `CHK(rd[4:3], e)
   endtask : probe
   task automatic t_rise;
      for (int c = 0; c < 16; c++)
      begin
         bus(1'b1, REG_TEMP_RISE_OFS, {24'h0, 4'ha, 4'(c)});
         `CHK(rise_tenths_c, 6'(c * 2 + 16))
      end
      $display("t_rise done");
   endtask : t_rise
   task automatic t_opts;
      for (int b = 0; b < 8; b++)
      begin
         bus(1'b1, REG_PACK_OPT_OFS, 32'(1 << b));
         `CHK(pack_opt, 8'(1 << b))
         `CHK(led_soc, (b == 7) ? 8'h5f : 8'h30)
         bus(1'b0, REG_STATUS_OFS, 32'h0);
         `CHK(rd[7:5], 3'((1 << b) >> 2))
      end
      for (int c = 0; c < 4; c++)
      begin
         bus(1'b1, REG_PACK_OPT_OFS, 32'(c));
         `CHK(cell_input_active, (c == 0) ? 4'h8 : 4'((1 << (c + 1)) - 1))
         `CHK(pack_voltage_out, cell_volt[(c == 0) ? 3 : c])
      end
      $display("t_opts done");
   endtask : t_opts
   task automatic t_lock;
      bus(1'b1, REG_PACK_OPT_OFS, 32'h0);
      probe(8'h50, 2'h3);
      bus(1'b1, REG_PACK_OPT_OFS, 32'h40);
      for (int k = 0; k < 8; k++)
         probe(cmd[k], acc[k]);
      bus(1'b1, REG_PACK_OPT_OFS, 32'h0);
      $display("t_lock done");
   endtask : t_lock
   task automatic t_regs;
      bus(1'b1, REG_RUN_ALARM_OFS, 32'h1234);
      bus(1'b1, REG_CAP_ALARM_OFS, 32'h0abc);
      bus(1'b0, REG_RUN_ALARM_OFS, 32'h0);
      `CHK(rd[15:0], 16'h1234)
      bus(1'b0, REG_CAP_ALARM_OFS, 32'h0);
      `CHK(rd[15:0], 16'h0abc)
      bus(1'b0, 10'h040, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b1, REG_CYC_THR_OFS, 32'hff9c);
      for (int k = 0; k < 2; k++)
      begin
         bus(1'b1, REG_DISCH_OFS, 32'd60);
         bus(1'b0, REG_CYCLE_OFS, 32'h0);
         `CHK(rd[15:0], 16'(k))
      end
      $display("t_regs done");
   endtask : t_regs
   task automatic t_term;
      bus(1'b1, REG_PACK_OPT_OFS, 32'h20);
      bus(1'b1, REG_HOLDOFF_OFS, 32'h0f);
      bus(1'b1, REG_WINDOW_OFS, 32'h0f);
      bus(1'b1, REG_RESYNC_PCT_OFS, 32'hb0);
      bus(1'b1, REG_FULL_CLR_OFS, 32'ha6);
      bus(1'b1, REG_GAUGE_OFS, {16'd1000, 16'd100});
      chg <= 1'b1;
      repeat (100) @(posedge clock);
      heat <= 1'b1;
      repeat (80) @(posedge clock);
      `CHK(charge_term, 1'b0)
      for (i = 0; charge_term !== 1'b1 && i < 60; i++)
         @(posedge clock);
      repeat (2) @(posedge clock);
      #1;
      `CHK(charge_term, 1'b1)
      `CHK(full_charged, 1'b1)
      bus(1'b0, REG_GAUGE_OFS, 32'h0);
      `CHK(rd[15:0], 16'd800)
      chg <= 1'b0;
      heat <= 1'b0;
      rel <= 8'h5a;
      for (i = 0; full_charged !== 1'b0 && i < 20; i++)
         @(posedge clock);
      `CHK(full_charged, 1'b0)
      $display("t_term done");
   endtask : t_term
   ////////////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic print_verdict;
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : print_verdict
   // Watchdog against a hang
   initial
   begin
      #40000;
      bad_count++;
      print_verdict();
   end
   // Main sequence
   initial
   begin
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      @(posedge clock);
      #1;
      t_rise();
      t_opts();
      t_lock();
      t_regs();
      t_term();
      print_verdict();
   end
endmodule : test_ctp_term_cfg
